// ### hdl/smi_status_enable_aggregator.sv
// SMI status and enable registers, group SMI and its three routes
// Functional notes
// RL1 - Status two bit 0 follows mouse source; writes never clear it.
// RL2 - Status two bits 1 and 4 follow keyboard and port pin sources.
// RL3 - Any edge on the selected infrared receive input sets status two bit 2.
// RL4 - A read of status two clears the infrared activity bit.
// RL5 - Status three to five latch; writing one clears, zero keeps.
// RL6 - Status three: pins 20-22 bits 0-2, 24-26 bits 4-6, 60 bit 7.
// RL7 - Status four: pins 30,31,32,33,41,42,43,61 on bits 0 to 7.
// RL8 - Status five: pins 54-57 bits 0-3, fans on bits 6 and 7.
// RL9 - Gap between status five and enable one reads zero.
// RL10 - Enable bit one passes its source to group SMI, zero blocks it.
// RL11 - Enable one: parallel, uarts, floppy, midi on 1-5, watchdog on 7.
// RL12 - Enable two bits 0,1,2,4: mouse, keyboard, infrared, port pin.
// RL13 - Enable two bit 5 sends group SMI into wake logic.
// RL14 - Enable two bit 6 sends group SMI into serial IRQ stream.
// RL15 - Enable two bit 7 drives active-low group SMI onto its pin.
// RL16 - Enable three uses the status three layout.
// RL17 - Enable four uses the status four layout.
// RL18 - Group SMI is OR of set-and-enabled bits, active low per route.
// RL19 - Reserved bits read zero; writes to source-cleared bits do nothing.
`timescale 1ns/1ns
module smi_status_enable_aggregator (
    // Clock and reset
    input  wire logic                              i_core_clk,
    input  wire logic                              i_reset,
    // Avalon-MM slave
    input  wire logic [7:0]                        i_avs_address,
    input  wire logic                              i_avs_read,
    input  wire logic                              i_avs_write,
    input  wire logic [31:0]                       i_avs_writedata,
    input  wire logic [3:0]                        i_avs_byteenable,
    output logic      [31:0]                       o_avs_readdata,
    output logic                                   o_avs_waitrequest,
    // Interrupt sources and infrared input select
    input  wire smi_aggregator_pkg::smi_sources_t  i_sources,
    input  wire logic                              i_infrared_select,
    // Group SMI routes, active low
    output logic                                   o_smi_output_pin_n,
    output logic                                   o_serial_irq_smi_n,
    output logic                                   o_wake_event_logic_n
);

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    smi_aggregator_pkg::smi_state_t   state;
    smi_aggregator_pkg::smi_state_t   next_state;
    smi_aggregator_pkg::smi_sources_t synced;
    logic [smi_aggregator_pkg::SOURCES_W-1:0] synced_bits;

    smi_input_sync #(
        .WIDTH (smi_aggregator_pkg::SOURCES_W)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_async    (i_sources),
        .o_sync     (synced_bits)
    );

    assign synced = smi_aggregator_pkg::smi_sources_t'(synced_bits);

    // Word index match for a byte address
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [5:0] idx);
        hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // Seven-bit source group into the layout with a reserved bit 3
    function automatic logic [7:0] three_layout(input logic [6:0] v);
        three_layout = {v[6:3], 1'b0, v[2:0]};
    endfunction

    // Any set-and-enabled bit
    function automatic logic any_enabled(input logic [7:0] sts,
                                         input logic [7:0] en);
        any_enabled = |(sts & en);
    endfunction

    logic       access;
    logic       write_ok;
    logic       read_ok;
    logic [7:0] wdata;
    logic       ir_now;
    logic       ir_edge;
    logic [7:0] rise_three;
    logic [7:0] rise_four;
    logic [7:0] rise_five;
    logic [7:0] clr_three;
    logic [7:0] clr_four;
    logic [7:0] clr_five;
    logic [7:0] legacy_bits;
    logic       group_smi;
    logic [7:0] read_mux;

    always_comb begin
        next_state = state;
        access     = (i_avs_read || i_avs_write) && !state.waitrequest;
        write_ok   = access && i_avs_write && i_avs_byteenable[0];
        read_ok    = access && i_avs_read;
        wdata      = i_avs_writedata[7:0];

        // Selection happens before the edge detector, so a change of the
        // select itself can look like activity; software should expect that
        ir_now  = i_infrared_select ? synced.infrared_receive_pin
                                    : synced.second_uart_receive_pin;
        ir_edge = ir_now ^ state.ir_prev;                          // [RL3]
        next_state.ir_prev      = ir_now;
        next_state.sources_prev = synced;

        rise_three = three_layout(synced.gpio_pin_sts3 &
                                  ~state.sources_prev.gpio_pin_sts3); // [RL6]
        rise_four  = synced.gpio_pin_sts4 &
                     ~state.sources_prev.gpio_pin_sts4;             // [RL7]
        rise_five  = {synced.fan_speed_input &
                      ~state.sources_prev.fan_speed_input,
                      2'b00,
                      synced.gpio_pin_54_57 &
                      ~state.sources_prev.gpio_pin_54_57};          // [RL8]

        clr_three = '0;
        clr_four  = '0;
        clr_five  = '0;
        if (write_ok) begin
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_THREE)) begin
                clr_three = wdata;
            end
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_FOUR)) begin
                clr_four = wdata;
            end
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_FIVE)) begin
                clr_five = wdata;
            end
        end

        // A new edge in the clearing cycle wins over the clear
        next_state.status_three = ((state.status_three & ~clr_three) |
            rise_three) & smi_aggregator_pkg::MASK_STATUS_THREE;   // [RL5]
        next_state.status_four  = ((state.status_four & ~clr_four) |
            rise_four) & smi_aggregator_pkg::MASK_STATUS_FOUR;     // [RL5]
        next_state.status_five  = ((state.status_five & ~clr_five) |
            rise_five) & smi_aggregator_pkg::MASK_STATUS_FIVE;     // [RL5]

        // Level bits mirror the source; writes are not looked at
        next_state.status_two[smi_aggregator_pkg::BIT_MOUSE_IRQ_STATUS] =
            synced.mouse_irq;                                      // [RL1]
        next_state.status_two[smi_aggregator_pkg::BIT_KBD_IRQ_STATUS] =
            synced.kbd_irq;                                        // [RL2]
        next_state.status_two[smi_aggregator_pkg::BIT_KBC_PORT_PIN_STATUS] =
            synced.kbc_port_pin;                                   // [RL2]
        if (ir_edge) begin
            next_state.status_two[
                smi_aggregator_pkg::BIT_INFRARED_ACTIVITY_STATUS] = 1'b1;
        end else if (read_ok &&
                     hit(i_avs_address,
                         smi_aggregator_pkg::IDX_STATUS_TWO)) begin
            next_state.status_two[
                smi_aggregator_pkg::BIT_INFRARED_ACTIVITY_STATUS] = 1'b0;
        end                                                        // [RL4]
        next_state.status_two = next_state.status_two &
            smi_aggregator_pkg::MASK_STATUS_TWO;                   // [RL19]

        if (write_ok) begin
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_ONE)) begin
                next_state.enable_one = wdata &
                    smi_aggregator_pkg::MASK_ENABLE_ONE;           // [RL11]
            end
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_TWO)) begin
                next_state.enable_two = wdata &
                    smi_aggregator_pkg::MASK_ENABLE_TWO;           // [RL12]
            end
            if (hit(i_avs_address,
                    smi_aggregator_pkg::IDX_ENABLE_THREE)) begin
                next_state.enable_three = wdata &
                    smi_aggregator_pkg::MASK_ENABLE_THREE;         // [RL16]
            end
            if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_FOUR)) begin
                next_state.enable_four = wdata &
                    smi_aggregator_pkg::MASK_ENABLE_FOUR;          // [RL17]
            end
        end

        // Legacy sources placed on their enable one bit positions
        legacy_bits = {synced.legacy_irq.watchdog_irq, 1'b0,
                       synced.legacy_irq.midi_irq,
                       synced.legacy_irq.floppy_irq,
                       synced.legacy_irq.uart_a_irq,
                       synced.legacy_irq.uart_b_irq,
                       synced.legacy_irq.parallel_irq, 1'b0};      // [RL11]

        // Status five has no enable register in this block, so it is
        // visible to software but never raises the group
        group_smi =
            any_enabled(legacy_bits, state.enable_one) ||
            any_enabled(state.status_two, state.enable_two &
                        smi_aggregator_pkg::MASK_STATUS_TWO) ||
            any_enabled(state.status_three, state.enable_three) ||
            any_enabled(state.status_four, state.enable_four); // [RL10] [RL18]

        next_state.smi_output_pin_n = !(group_smi && state.enable_two[
            smi_aggregator_pkg::BIT_ROUTE_GROUP_TO_PIN]);          // [RL15]
        next_state.serial_irq_smi_n = !(group_smi && state.enable_two[
            smi_aggregator_pkg::BIT_ROUTE_GROUP_TO_SERIAL_IRQ]);   // [RL14]
        next_state.wake_event_logic_n = !(group_smi && state.enable_two[
            smi_aggregator_pkg::BIT_ROUTE_GROUP_TO_WAKE]);         // [RL13]

        // Unmapped and reserved offsets read as zero
        read_mux = 8'h00;                                          // [RL9]
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_TWO)) begin
            read_mux = state.status_two;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_THREE)) begin
            read_mux = state.status_three;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_FOUR)) begin
            read_mux = state.status_four;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_FIVE)) begin
            read_mux = state.status_five;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_ONE)) begin
            read_mux = state.enable_one;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_TWO)) begin
            read_mux = state.enable_two;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_THREE)) begin
            read_mux = state.enable_three;
        end
        if (hit(i_avs_address, smi_aggregator_pkg::IDX_ENABLE_FOUR)) begin
            read_mux = state.enable_four;
        end

        // One wait cycle: data is captured on the same edge that drops waitrequest
        if ((i_avs_read || i_avs_write) && state.waitrequest) begin
            next_state.waitrequest = 1'b0;
            next_state.readdata    = i_avs_read ? read_mux : 8'h00;
        end else begin
            next_state.waitrequest = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state                    <= '0;
            state.status_two         <= smi_aggregator_pkg::RST_STATUS;
            state.status_three       <= smi_aggregator_pkg::RST_STATUS;
            state.status_four        <= smi_aggregator_pkg::RST_STATUS;
            state.status_five        <= smi_aggregator_pkg::RST_STATUS;
            state.enable_one         <= smi_aggregator_pkg::RST_ENABLE;
            state.enable_two         <= smi_aggregator_pkg::RST_ENABLE;
            state.enable_three       <= smi_aggregator_pkg::RST_ENABLE;
            state.enable_four        <= smi_aggregator_pkg::RST_ENABLE;
            state.waitrequest        <= 1'b1;
            state.smi_output_pin_n   <= 1'b1;
            state.serial_irq_smi_n   <= 1'b1;
            state.wake_event_logic_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign o_avs_readdata       = {24'h000000, state.readdata};
    assign o_avs_waitrequest    = state.waitrequest;
    assign o_smi_output_pin_n   = state.smi_output_pin_n;
    assign o_serial_irq_smi_n   = state.serial_irq_smi_n;
    assign o_wake_event_logic_n = state.wake_event_logic_n;

    property p_mouse_follows;
        ##1 state.status_two[0] == $past(synced.mouse_irq);
    endproperty
    a_mouse_follows: assert property (p_mouse_follows) // [RL1]
        else $error("mouse status does not follow its source");

    property p_kbd_port_follow;
        ##1 state.status_two[1] == $past(synced.kbd_irq) &&
            state.status_two[4] == $past(synced.kbc_port_pin);
    endproperty
    a_kbd_port_follow: assert property (p_kbd_port_follow) // [RL2]
        else $error("keyboard or port pin status does not follow source");

    property p_ir_edge_sets;
        ir_edge |=> state.status_two[2];
    endproperty
    a_ir_edge_sets: assert property (p_ir_edge_sets) // [RL3]
        else $error("infrared edge did not set activity bit");

    property p_read_clears_ir;
        (read_ok && hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_TWO)
         && !ir_edge) |=> !state.status_two[2];
    endproperty
    a_read_clears_ir: assert property (p_read_clears_ir) // [RL4]
        else $error("status two read did not clear activity bit");

    property p_w1c_clears;
        (write_ok && hit(i_avs_address, smi_aggregator_pkg::IDX_STATUS_FOUR)
         && wdata[0] && !rise_four[0]) |=> !state.status_four[0];
    endproperty
    a_w1c_clears: assert property (p_w1c_clears) // [RL5]
        else $error("write of one did not clear latched status");

    property p_w0_keeps;
        (state.status_three[0] && !clr_three[0]) |=> state.status_three[0];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps) // [RL5]
        else $error("latched status lost without a clear");

    property p_gap_reads_zero;
        (i_avs_read && state.waitrequest &&
         hit(i_avs_address, smi_aggregator_pkg::IDX_GAP))
        |=> !state.waitrequest && state.readdata == 8'h00;
    endproperty
    a_gap_reads_zero: assert property (p_gap_reads_zero) // [RL9]
        else $error("reserved gap did not read zero in one cycle");

    property p_disabled_quiet;
        (state.enable_one == 8'h00 && state.enable_two[4:0] == 5'h00 &&
         state.enable_three == 8'h00 && state.enable_four == 8'h00)
        |=> state.smi_output_pin_n && state.serial_irq_smi_n &&
            state.wake_event_logic_n;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) // [RL10]
        else $error("group SMI asserted with every source disabled");

    property p_pin_route;
        (group_smi && state.enable_two[7]) |=> !state.smi_output_pin_n;
    endproperty
    a_pin_route: assert property (p_pin_route) // [RL15]
        else $error("pin route did not drive group SMI low");

    property p_other_routes;
        ##1 state.serial_irq_smi_n == !$past(group_smi && state.enable_two[6])
         && state.wake_event_logic_n == !$past(group_smi &&
                                               state.enable_two[5]);
    endproperty
    a_other_routes: assert property (p_other_routes) // [RL13] [RL14]
        else $error("serial or wake route disagrees with group SMI");

    property p_reserved_zero;
        ((state.status_two & ~smi_aggregator_pkg::MASK_STATUS_TWO) == 8'h00)
        && state.status_three[3] == 1'b0
        && state.status_five[5:4] == 2'b00 && state.enable_one[6] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // [RL19]
        else $error("a reserved bit is set");

endmodule

// ### hdl/smi_aggregator_pkg.sv
// Constants, field layouts and carrier types for the SMI aggregator
package smi_aggregator_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [5:0] IDX_STATUS_TWO   = 6'h11;
    localparam logic [5:0] IDX_STATUS_THREE = 6'h12;
    localparam logic [5:0] IDX_STATUS_FOUR  = 6'h13;
    localparam logic [5:0] IDX_STATUS_FIVE  = 6'h14;
    localparam logic [5:0] IDX_GAP          = 6'h15;
    localparam logic [5:0] IDX_ENABLE_ONE   = 6'h16;
    localparam logic [5:0] IDX_ENABLE_TWO   = 6'h17;
    localparam logic [5:0] IDX_ENABLE_THREE = 6'h18;
    localparam logic [5:0] IDX_ENABLE_FOUR  = 6'h19;

    // Reset values
    localparam logic [7:0] RST_STATUS = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;

    // Implemented bits; all others are reserved and read as zero
    localparam logic [7:0] MASK_STATUS_TWO   = 8'h17;
    localparam logic [7:0] MASK_STATUS_THREE = 8'hF7;
    localparam logic [7:0] MASK_STATUS_FOUR  = 8'hFF;
    localparam logic [7:0] MASK_STATUS_FIVE  = 8'hCF;
    localparam logic [7:0] MASK_ENABLE_ONE   = 8'hBE;
    localparam logic [7:0] MASK_ENABLE_TWO   = 8'hF7;
    localparam logic [7:0] MASK_ENABLE_THREE = 8'hF7;
    localparam logic [7:0] MASK_ENABLE_FOUR  = 8'hFF;

    // Status register two fields
    localparam int BIT_MOUSE_IRQ_STATUS         = 0;
    localparam int BIT_KBD_IRQ_STATUS           = 1;
    localparam int BIT_INFRARED_ACTIVITY_STATUS = 2;
    localparam int BIT_KBC_PORT_PIN_STATUS      = 4;

    // Enable register two route bits
    localparam int BIT_ROUTE_GROUP_TO_WAKE       = 5;
    localparam int BIT_ROUTE_GROUP_TO_SERIAL_IRQ = 6;
    localparam int BIT_ROUTE_GROUP_TO_PIN        = 7;

    // Status register five fields
    localparam int LSB_STATUS_FIVE_GPIO = 0;
    localparam int LSB_STATUS_FIVE_FAN  = 6;

    // Reserved bit inside the status/enable three layout
    localparam int BIT_THREE_RESERVED = 3;

    // Legacy interrupt sources, order gives enable one bits 7,5,4,3,2,1
    typedef struct packed {
        logic watchdog_irq;
        logic midi_irq;
        logic floppy_irq;
        logic uart_a_irq;
        logic uart_b_irq;
        logic parallel_irq;
    } legacy_irq_t;

    // All raw interrupt sources, as they arrive from pins or other blocks
    typedef struct packed {
        logic [1:0]  fan_speed_input;  // [0] one, [1] two
        logic [3:0]  gpio_pin_54_57;   // [0] pin 54 .. [3] pin 57
        logic [7:0]  gpio_pin_sts4;    // 30,31,32,33,41,42,43,61 at [0]..[7]
        logic [6:0]  gpio_pin_sts3;    // 20,21,22,24,25,26,60 at [0]..[6]
        legacy_irq_t legacy_irq;
        logic        infrared_receive_pin;
        logic        second_uart_receive_pin;
        logic        kbc_port_pin;
        logic        kbd_irq;
        logic        mouse_irq;
    } smi_sources_t;

    localparam int SOURCES_W = $bits(smi_sources_t);

    // Whole state of the aggregator
    typedef struct packed {
        smi_sources_t sources_prev;
        logic         ir_prev;
        logic [7:0]   status_two;
        logic [7:0]   status_three;
        logic [7:0]   status_four;
        logic [7:0]   status_five;
        logic [7:0]   enable_one;
        logic [7:0]   enable_two;
        logic [7:0]   enable_three;
        logic [7:0]   enable_four;
        logic         waitrequest;
        logic [7:0]   readdata;
        logic         smi_output_pin_n;
        logic         serial_irq_smi_n;
        logic         wake_event_logic_n;
    } smi_state_t;

endpackage

// ### hdl/smi_input_sync.sv
// Two-flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ns
module smi_input_sync #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    // Data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    typedef struct packed {
        logic [WIDTH-1:0] stage_one;
        logic [WIDTH-1:0] stage_two;
    } sync_state_t;

    sync_state_t state;
    sync_state_t next_state;

    // Stage one feeds only stage two, never any logic
    always_comb begin
        next_state           = state;
        next_state.stage_one = i_async;
        next_state.stage_two = state.stage_one;
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_sync = state.stage_two;

endmodule

// ### sim/smi_host_model.sv
// Host chipset model that counts group SMI events on pin and serial routes
`timescale 1ns/1ns
module smi_host_model (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_reset,
    // Active-low routes from the device
    input  wire logic i_smi_pin_n,
    input  wire logic i_serial_smi_n,
    // Number of new group SMI events seen
    output int        o_smi_count
);
    logic prev;
    // An event is either route going low while both were high, both read as active low
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            prev <= 1'b0;
            o_smi_count <= 0;
        end else begin
            prev <= !(i_smi_pin_n && i_serial_smi_n);
            if (!prev && !(i_smi_pin_n && i_serial_smi_n))
                o_smi_count <= o_smi_count + 1;
        end
    end
endmodule

// ### sim/smi_status_enable_aggregator_tb_top.sv
// Self-checking bench for the SMI status and enable aggregator
`timescale 1ns/1ns
module smi_status_enable_aggregator_tb_top;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    logic        clk = 0, rst = 1, rd = 0, wr = 0, irsel = 0;
    logic [7:0]  adr = 8'h00, q;
    logic [31:0] wd = 32'h0, rdata;
    logic        wreq, pin_n, ser_n, wake_n;
    logic [3:0]  be = 4'hF;
    int          n_errors = 0, checks = 0, seen;
    smi_aggregator_pkg::smi_sources_t src = '0;
    row_t rows[8] = '{'{8'h58, 8'hFF, 8'hBE}, '{8'h5C, 8'hFF, 8'hF7},
        '{8'h60, 8'hFF, 8'hF7}, '{8'h64, 8'hFF, 8'hFF},
        '{8'h54, 8'hFF, 8'h00}, '{8'h44, 8'hFF, 8'h00},
        '{8'h48, 8'hFF, 8'h00}, '{8'h59, 8'hFF, 8'h00}};
    always #5 clk = ~clk;
    smi_status_enable_aggregator smi_status_enable_aggregator_inst (
        .i_core_clk(clk), .i_reset(rst), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_sources(src),
        .i_infrared_select(irsel), .o_smi_output_pin_n(pin_n),
        .o_serial_irq_smi_n(ser_n), .o_wake_event_logic_n(wake_n));
    smi_host_model smi_host_model_inst (
        .i_core_clk(clk), .i_reset(rst), .i_smi_pin_n(pin_n),
        .i_serial_smi_n(ser_n), .o_smi_count(seen));
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    // Request held until waitrequest is sampled low; no fixed latency assumed
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h0, d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk("readback", e, q);
    endtask
    task automatic pins(input logic [2:0] e);
        repeat (6) @(posedge clk);
        chk("routes", {5'h0, e}, {5'h0, pin_n, ser_n, wake_n});
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        pins(3'b111);
        for (int i = 0; i < 9; i++) rchk(8'h44 + 8'(4 * i), 8'h00);
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e);
        end
        for (int i = 0; i < 4; i++) bus(1'b1, 8'h58 + 8'(4 * i), 8'h00);
        bus(1'b1, 8'h5C, 8'hE1);
        src.mouse_irq <= 1'b1;
        pins(3'b000);
        chk("host", 8'h01, {7'h0, seen > 0});
        bus(1'b1, 8'h44, 8'hFF);
        rchk(8'h44, 8'h01);
        for (int b = 5; b < 8; b++) begin
            bus(1'b1, 8'h5C, 8'h01 | (8'h01 << b));
            pins(~(3'b001 << (b - 5)));
        end
        bus(1'b1, 8'h5C, 8'hE0);
        pins(3'b111);
        src.mouse_irq <= 1'b0;
        src.kbd_irq <= 1'b1;
        src.kbc_port_pin <= 1'b1;
        pins(3'b111);
        rchk(8'h44, 8'h12);
        src.kbd_irq <= 1'b0;
        src.kbc_port_pin <= 1'b0;
        bus(1'b1, 8'h5C, 8'h84);
        src.second_uart_receive_pin <= 1'b1;
        pins(3'b011);
        rchk(8'h44, 8'h04);
        rchk(8'h44, 8'h00);
        pins(3'b111);
        src.second_uart_receive_pin <= 1'b0;
        pins(3'b011);
        rchk(8'h44, 8'h04);
        irsel <= 1'b1;
        src.infrared_receive_pin <= 1'b1;
        repeat (6) @(posedge clk);
        rchk(8'h44, 8'h04);
        rchk(8'h44, 8'h00);
        bus(1'b1, 8'h5C, 8'h80);
        src[31:11] <= 21'h1FFFFF;
        pins(3'b111);
        rchk(8'h48, 8'hF7);
        rchk(8'h4C, 8'hFF);
        rchk(8'h50, 8'hCF);
        bus(1'b1, 8'h48, 8'h00);
        rchk(8'h48, 8'hF7);
        bus(1'b1, 8'h60, 8'h80);
        pins(3'b011);
        bus(1'b1, 8'h60, 8'h00);
        bus(1'b1, 8'h64, 8'h01);
        pins(3'b011);
        bus(1'b1, 8'h64, 8'h00);
        pins(3'b111);
        for (int i = 0; i < 3; i++) begin
            bus(1'b1, 8'h48 + 8'(4 * i), 8'hFF);
            rchk(8'h48 + 8'(4 * i), 8'h00);
        end
        src.legacy_irq.watchdog_irq <= 1'b1;
        bus(1'b1, 8'h58, 8'h80);
        pins(3'b011);
        bus(1'b1, 8'h58, 8'h00);
        pins(3'b111);
        // Low byte lane off: the write must not land
        be <= 4'hE;
        bus(1'b1, 8'h58, 8'h80);
        be <= 4'hF;
        rchk(8'h58, 8'h00);
        bus(1'b1, 8'h58, 8'h80);
        pins(3'b011);
        // Mid-run reset with the pin route active
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        pins(3'b111);
        rchk(8'h58, 8'h00);
        rchk(8'h5C, 8'h00);
        rchk(8'h48, 8'hF7);
        summarize();
    end
endmodule
